//--- hdl/rsc_pkg.sv
// package for the reset sequencer and clock select block
// assumes a single 40 MHz reference clock and no register bus
package rsc_pkg;
    // stabilization delay counts in cpu clock cycles
    localparam int unsigned RSC_DLY_SHORT = 256;
    localparam int unsigned RSC_DLY_LONG = 4096;
    localparam int unsigned RSC_CNT_W = 13;
    // vector fetch length in cycles
    localparam int unsigned RSC_FETCH_CYC = 2;
    // reset vector location
    localparam logic [15:0] RSC_VEC_LO = 16'hFFFE;
    localparam logic [15:0] RSC_VEC_HI = 16'hFFFF;
    // minimum output reset width
    localparam int unsigned RSC_CLK_HZ = 40000000;
    localparam int unsigned RSC_MIN_RST_NS = 20000;
    localparam int unsigned RSC_MIN_RST_CYC =
        (RSC_MIN_RST_NS * (RSC_CLK_HZ / 1000000) + 999) / 1000;
    // oscillator source selection encodings
    localparam logic [2:0] RSC_SRC_EXT = 3'h0;
    localparam logic [2:0] RSC_SRC_XT0 = 3'h1;
    localparam logic [2:0] RSC_SRC_XT1 = 3'h2;
    localparam logic [2:0] RSC_SRC_XT2 = 3'h3;
    localparam logic [2:0] RSC_SRC_XT3 = 3'h4;
    localparam logic [2:0] RSC_SRC_RC = 3'h5;

    // sequencer states, gray along the path
    typedef enum logic [2:0] {
        RSC_ST_ACTIVE = 3'h0,
        RSC_ST_DELAY = 3'h1,
        RSC_ST_FETCH_LO = 3'h3,
        RSC_ST_FETCH_HI = 3'h2,
        RSC_ST_RUN = 3'h6
    } rsc_state_t;
endpackage

//--- hdl/rsc_clk_if.sv
// carrier between sequencer and clock selector
// assumes both ends run on the reference clock
`timescale 1ns/100ps
interface rsc_clk_if;
    logic [2:0] src_sel;
    logic pll_en;
    logic xtal_run;
    logic core_en;
    logic rc_pll_warn;
    modport ctl (output src_sel, output pll_en,
        input xtal_run, input core_en, input rc_pll_warn);
    modport sel (input src_sel, input pll_en,
        output xtal_run, output core_en, output rc_pll_warn);
endinterface

//--- hdl/rsc_clock_select.sv
// clock source select and core clock enable generator
// assumes the oscillator clock is sampled as enable pulses on one clock
`timescale 1ns/100ps
module rsc_clock_select
    import rsc_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // oscillator tick, already synchronised
    input wire logic i_osc_tick,
    // carrier
    rsc_clk_if.sel cif
);
    logic div_r;
    logic div_nxt;
    logic en_r;
    logic en_nxt;
    logic is_xtal;
    logic xtal_r;
    logic warn_r;

    assign is_xtal = (cif.src_sel >= RSC_SRC_XT0) &&
        (cif.src_sel <= RSC_SRC_XT3);
    // pll uses each tick, otherwise every second tick is used
    assign div_nxt = i_osc_tick ? ~div_r : div_r;
    assign en_nxt = cif.pll_en ? i_osc_tick
        : (i_osc_tick & div_r);

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_r <= 1'b0;
            en_r <= 1'b0;
            xtal_r <= 1'b0;
            warn_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            en_r <= en_nxt;
            xtal_r <= is_xtal; // crystal flag cleared in reset, follows select after
            warn_r <= cif.pll_en && (cif.src_sel == RSC_SRC_RC);
        end
    end

    assign cif.core_en = en_r;
    assign cif.xtal_run = xtal_r;
    assign cif.rc_pll_warn = warn_r;
endmodule // rsc_clock_select

//--- hdl/rsc_reset_sequence_manager.sv
// reset sequence manager with clock source selection
// assumes option bits are static and the reset pin has an external pull-up
`timescale 1ns/100ps
module rsc_reset_sequence_manager
    import rsc_pkg::*;
#(
    parameter int unsigned MIN_RST_CYC = RSC_MIN_RST_CYC
)(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // reset pin, open drain
    input wire logic i_rst_pin,
    output logic o_rst_pin,
    output logic o_rst_pin_oe_n,
    // internal reset sources
    input wire logic i_low_voltage_detector,
    input wire logic i_wdg_underflow,
    // option bits
    input wire logic i_opt_long_dly,
    input wire logic i_opt_pll_en,
    input wire logic [2:0] i_multi_oscillator_select,
    // oscillator clock tick
    input wire logic i_osc_tick,
    // status toward the core
    output logic o_core_rst,
    output logic o_vec_fetch,
    output logic [15:0] o_vec_addr,
    output logic o_core_clk_en,
    output logic o_xtal_run,
    output logic o_rc_pll_warn
);
    rsc_clk_if cif();
    rsc_state_t st_r;
    rsc_state_t st_nxt;
    logic ext_latch_r;
    logic pin_s1_r;
    logic pin_s2_r;
    logic lvd_s1_r;
    logic lvd_s2_r;
    logic tick_s1_r;
    logic tick_s2_r;
    logic [RSC_CNT_W-1:0] dly_r;
    logic [RSC_CNT_W-1:0] dly_nxt;
    logic [15:0] str_r;
    logic [15:0] str_nxt;
    logic [2:0] own_drv_r;
    logic any_src;
    logic stretch_on;
    logic dly_done;
    logic [RSC_CNT_W-1:0] dly_last;
    logic drive_low;
    logic pin_low_ext;

    // set straight from the pad so a halted clock still catches a pulse
    always_ff @(posedge i_ref_clk or negedge i_rst_pin) begin
        if (!i_rst_pin) begin
            ext_latch_r <= 1'b1;
        end else begin
            ext_latch_r <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
            lvd_s1_r <= 1'b1;
            lvd_s2_r <= 1'b1;
            tick_s1_r <= 1'b0;
            tick_s2_r <= 1'b0;
            own_drv_r <= 3'h7;
        end else begin
            pin_s1_r <= ~ext_latch_r;
            pin_s2_r <= pin_s1_r;
            lvd_s1_r <= i_low_voltage_detector;
            lvd_s2_r <= lvd_s1_r;
            tick_s1_r <= i_osc_tick;
            tick_s2_r <= tick_s1_r;
            own_drv_r <= {own_drv_r[1:0], drive_low};
        end
    end

    // external request is seen from the synchronised pin level; our own
    // drive takes three cycles to leave the pin path after release
    assign pin_low_ext = ~pin_s2_r & ~drive_low & ~(|own_drv_r);
    assign stretch_on = (str_r != 16'h0000);
    // pin stays low through stretch and delay phases
    assign any_src = pin_low_ext | lvd_s2_r | stretch_on;
    assign dly_last = i_opt_long_dly ? RSC_CNT_W'(RSC_DLY_LONG - 1)
        : RSC_CNT_W'(RSC_DLY_SHORT - 1);
    assign dly_done = cif.core_en && (dly_r == dly_last);

    // stretch counter reloads on recognised pulse or watchdog underflow
    always_comb begin
        str_nxt = str_r;
        if (i_wdg_underflow) begin
            str_nxt = 16'(MIN_RST_CYC);
        end else if (pin_low_ext && !stretch_on) begin
            str_nxt = 16'(MIN_RST_CYC);
        end else if (stretch_on) begin
            str_nxt = str_r - 16'h0001;
        end
    end

    always_comb begin
        dly_nxt = dly_r;
        if (any_src) begin
            dly_nxt = '0;
        end else if (st_r == RSC_ST_DELAY && cif.core_en) begin
            dly_nxt = dly_r + RSC_CNT_W'(1);
        end
    end

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            RSC_ST_ACTIVE: begin
                if (!any_src) begin
                    st_nxt = RSC_ST_DELAY;
                end
            end
            RSC_ST_DELAY: begin
                if (any_src) begin
                    st_nxt = RSC_ST_ACTIVE;
                end else if (dly_done) begin
                    st_nxt = RSC_ST_FETCH_LO;
                end
            end
            RSC_ST_FETCH_LO: begin
                st_nxt = RSC_ST_FETCH_HI;
            end
            RSC_ST_FETCH_HI: begin
                st_nxt = RSC_ST_RUN;
            end
            RSC_ST_RUN: begin
                st_nxt = RSC_ST_RUN;
            end
            default: begin
                st_nxt = RSC_ST_ACTIVE;
            end
        endcase
        if (any_src) begin
            st_nxt = RSC_ST_ACTIVE;
        end
    end

    // pin driven low during active and delay phases
    assign drive_low = (st_r == RSC_ST_ACTIVE) || (st_r == RSC_ST_DELAY);

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= RSC_ST_ACTIVE;
            dly_r <= '0;
            str_r <= 16'h0000;
        end else begin
            st_r <= st_nxt;
            dly_r <= dly_nxt;
            str_r <= str_nxt;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rst_pin <= 1'b0;
            o_rst_pin_oe_n <= 1'b0;
            o_core_rst <= 1'b1;
            o_vec_fetch <= 1'b0;
            o_vec_addr <= RSC_VEC_LO;
            o_core_clk_en <= 1'b0;
            o_xtal_run <= 1'b0;
            o_rc_pll_warn <= 1'b0;
        end else begin
            o_rst_pin <= 1'b0;
            // open drain: enable low only while pulling low
            o_rst_pin_oe_n <= ~(st_nxt == RSC_ST_ACTIVE ||
                st_nxt == RSC_ST_DELAY);
            o_core_rst <= (st_nxt != RSC_ST_RUN);
            o_vec_fetch <= (st_nxt == RSC_ST_FETCH_LO) ||
                (st_nxt == RSC_ST_FETCH_HI);
            o_vec_addr <= (st_nxt == RSC_ST_FETCH_HI) ? RSC_VEC_HI
                : RSC_VEC_LO;
            o_core_clk_en <= cif.core_en;
            o_xtal_run <= cif.xtal_run;
            o_rc_pll_warn <= cif.rc_pll_warn;
        end
    end

    assign cif.src_sel = i_multi_oscillator_select;
    assign cif.pll_en = i_opt_pll_en;

    rsc_clock_select u_clk (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_osc_tick(tick_s2_r),
        .cif(cif)
    );
endmodule // rsc_reset_sequence_manager

//--- verification/rsc_ext_reset.sv
// external reset circuit model on the open-drain reset pin
// assumes the bench ties the pin to a pull-up and ands in the device drive
`timescale 1ns/100ps
module rsc_ext_reset (
    // clock
    input wire logic i_clk,
    // pulse request and its length in cycles
    input wire logic i_go,
    input wire logic [31:0] i_len,
    // pull toward ground
    output logic o_pull_low
);
    // held low from power-up while the memory is still blank
    int cnt_r = 20;
    always @(posedge i_clk) begin
        if (i_go)
            cnt_r <= i_len;
        else if (cnt_r != 0)
            cnt_r <= cnt_r - 1;
    end
    // open drain: only ever pulls low, the pull-up does the rest
    assign o_pull_low = (cnt_r != 0);
endmodule // rsc_ext_reset

//--- verification/rsc_props.sv
// port assertions for the reset sequence manager
// assumes a bind onto the design top, one clock, async active-low reset
`timescale 1ns/100ps
module rsc_props
    import rsc_pkg::*;
#(
    parameter int unsigned MIN_RST_CYC = RSC_MIN_RST_CYC
)(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // pin and sources
    input wire logic i_rst_pin,
    input wire logic o_rst_pin,
    input wire logic o_rst_pin_oe_n,
    input wire logic i_low_voltage_detector,
    input wire logic i_wdg_underflow,
    input wire logic [2:0] i_multi_oscillator_select,
    // core side
    input wire logic o_core_rst,
    input wire logic o_vec_fetch,
    input wire logic [15:0] o_vec_addr,
    input wire logic o_xtal_run
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    int unsigned low_r;
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
        if (!i_rst_n)
            low_r <= 0;
        else
            low_r <= o_rst_pin_oe_n ? 0 : low_r + 1;
    a_fetch_pair: assert property ($rose(o_vec_fetch) |->
        o_vec_addr == RSC_VEC_LO ##1 o_vec_fetch && o_vec_addr == RSC_VEC_HI
        ##1 !o_vec_fetch) else $error("vector fetch wrong");
    a_run_order: assert property ($fell(o_core_rst) |->
        $past(o_vec_addr) == RSC_VEC_HI && o_rst_pin_oe_n)
        else $error("run entered out of order");
    a_drive_zero: assert property (!o_rst_pin_oe_n |-> !o_rst_pin)
        else $error("pin driven high");
    a_min_width: assert property ($rose(o_rst_pin_oe_n) |->
        low_r >= MIN_RST_CYC) else $error("pin low too short");
    a_wdg_pull: assert property (i_wdg_underflow |->
        ##[1:4] !o_rst_pin_oe_n) else $error("watchdog not on pin");
    a_ext_pull: assert property ($fell(i_rst_pin) && o_rst_pin_oe_n |->
        ##[1:6] !o_rst_pin_oe_n) else $error("pin pulse not taken");
    a_lvd_hold: assert property (i_low_voltage_detector [*6] |->
        !o_rst_pin_oe_n) else $error("detector not on pin");
    a_src_restart: assert property (i_wdg_underflow |->
        ##3 (o_core_rst && !o_vec_fetch) [*8]) else $error("no restart");
    // the crystal flag needs two edges after reset to reach the pin
    a_xtal_kept: assert property (
        $stable(i_multi_oscillator_select) && $past(i_rst_n) |=>
        o_xtal_run == (i_multi_oscillator_select inside
        {[RSC_SRC_XT0:RSC_SRC_XT3]})) else $error("crystal run wrong");
endmodule // rsc_props
bind rsc_reset_sequence_manager rsc_props #(.MIN_RST_CYC(MIN_RST_CYC)) u_p (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_rst_pin(i_rst_pin),
    .o_rst_pin(o_rst_pin), .o_rst_pin_oe_n(o_rst_pin_oe_n),
    .i_low_voltage_detector(i_low_voltage_detector),
    .i_wdg_underflow(i_wdg_underflow),
    .i_multi_oscillator_select(i_multi_oscillator_select),
    .o_core_rst(o_core_rst), .o_vec_fetch(o_vec_fetch),
    .o_vec_addr(o_vec_addr), .o_xtal_run(o_xtal_run));

//--- verification/tb.sv
// self-checking bench for the reset sequence manager
// assumes the pin has a pull-up and an external reset circuit model
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
num_errors++; $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module tb;
    import rsc_pkg::*;
    localparam int MIN = 12;
    logic clk = 0, rst_n = 0, low_voltage_detector = 0, wdg = 0, lng = 0, pll = 0, tick = 0;
    logic go = 0, ext_low, oe_n, pin_o, core_rst, vf, cen, xr, warn;
    logic [2:0] sel = 3'h0;
    logic [15:0] va;
    wire pin = !(ext_low || (!oe_n && !pin_o));
    int num_errors = 0, samples_checked = 0, cyc = 0, n, dl = 8;
    int dcnt = 0, tcnt = 0;
    integer seed = 32'h8B6B;
    always #12.5 clk = ~clk;
    rsc_ext_reset ext (.i_clk(clk), .i_go(go), .i_len(dl),
        .o_pull_low(ext_low));
    rsc_reset_sequence_manager #(.MIN_RST_CYC(MIN)) dut (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_rst_pin(pin),
        .o_rst_pin(pin_o), .o_rst_pin_oe_n(oe_n),
        .i_low_voltage_detector(low_voltage_detector), .i_wdg_underflow(wdg),
        .i_opt_long_dly(lng), .i_opt_pll_en(pll),
        .i_multi_oscillator_select(sel), .i_osc_tick(tick),
        .o_core_rst(core_rst), .o_vec_fetch(vf), .o_vec_addr(va),
        .o_core_clk_en(cen), .o_xtal_run(xr), .o_rc_pll_warn(warn));
    // ticks and enables counted since the last active source
    always @(posedge clk) begin
        cyc++;
        tick <= #1 (($random(seed) & 3) != 0);
        // a pull while the device drives the pin itself is not seen
        if (!rst_n || low_voltage_detector || wdg || (ext_low && oe_n)) begin
            dcnt <= 0;
            tcnt <= 0;
        end else if (core_rst && !vf) begin
            dcnt <= dcnt + cen;
            tcnt <= tcnt + tick;
        end
        if (cyc == 100000) begin
            num_errors++;
            finish_test();
        end
    end
    function automatic int exp_dly(input logic l);
        return l ? int'(RSC_DLY_LONG) : int'(RSC_DLY_SHORT);
    endfunction
    task automatic finish_test();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check_seq(input int e);
        int t = 0;
        while (vf !== 1'b1 && t < 30000) begin
            @(posedge clk) #1;
            t++;
        end
        `CHK("fetch", 1'b1, vf)
        `CHK("lo", RSC_VEC_LO, va)
        // cen now shows the last pulse that the delay counter took
        `CHK("dly", 1'b1, dcnt + cen >= e && dcnt + cen <= e + 20)
        n = tcnt - (pll ? 1 : 2) * dcnt;
        `CHK("clk", 1'b1, n > -10 && n < 10)
        @(posedge clk) #1;
        `CHK("hi", RSC_VEC_HI, va)
        repeat (2) @(posedge clk) #1;
        `CHK("run", 3'b010, {core_rst, oe_n, vf})
        `CHK("xtal", sel >= RSC_SRC_XT0 && sel <= RSC_SRC_XT3, xr)
        `CHK("warn", sel == RSC_SRC_RC && pll, warn)
    endtask
    // each pass: boot with one option set, then a source from run
    initial begin
        for (int k = 0; k < 6; k++) begin
            rst_n = 0;
            lng = k[0];
            pll = k[1] || (k == 5);
            sel = 3'(k);
            repeat (2) @(posedge clk);
            #1 rst_n = 1;
            check_seq(exp_dly(lng));
            dl = 6 + ($random(seed) & 7);
            if (k % 3 == 0)
                go = 1;
            else if (k % 3 == 1)
                low_voltage_detector = 1;
            else
                wdg = 1;
            @(posedge clk) #1 {go, wdg} = 2'b00;
            repeat (dl) @(posedge clk);
            #1 low_voltage_detector = 0;
            if (k == 1) begin
                repeat (60) @(posedge clk);
                #1 wdg = 1;
                @(posedge clk) #1 wdg = 0;
            end
            check_seq(exp_dly(lng));
        end
        finish_test();
    end
endmodule // tb
